// ---- logic/iof_pkg.sv ----
// package of the image output formatter: variable map, field layout,
// reset values, output-stage sizes and the carrier types.
// assumes one master clock domain and one link clock domain.
`default_nettype none
package iof_pkg;
	// variable byte offsets; 16-bit variables take offset and offset+1
	localparam logic [4:0] OFS_DISPATCH = 5'h00;
	localparam logic [4:0] OFS_COLS     = 5'h02;
	localparam logic [4:0] OFS_ROWS     = 5'h04;
	localparam logic [4:0] OFS_ENCODING = 5'h06;
	localparam logic [4:0] OFS_SETUP    = 5'h07;
	localparam logic [4:0] OFS_RESYNC   = 5'h08;
	localparam logic [4:0] OFS_QS1      = 5'h0a;
	localparam logic [4:0] OFS_QS2      = 5'h0b;
	localparam logic [4:0] OFS_QS3      = 5'h0c;
	localparam logic [4:0] OFS_WAIT_LIM = 5'h0d;
	localparam logic [4:0] OFS_PHASE    = 5'h0e;
	localparam logic [4:0] OFS_LEN_UP   = 5'h0f;
	localparam logic [4:0] OFS_LEN_LO   = 5'h10;
	// reset values
	localparam logic [15:0] RST_DISPATCH = 16'he453;
	localparam logic [15:0] RST_COLS     = 16'h0640;
	localparam logic [15:0] RST_ROWS     = 16'h04b0;
	localparam logic [7:0]  RST_ENCODING = 8'h00;
	localparam logic [7:0]  RST_SETUP    = 8'h34;
	localparam logic [15:0] RST_RESYNC   = 16'h0000;
	localparam logic [7:0]  RST_QS1      = 8'h06;
	localparam logic [7:0]  RST_QS2      = 8'h09;
	localparam logic [7:0]  RST_QS3      = 8'h0c;
	localparam logic [7:0]  RST_WAIT_LIM = 8'h0a;
	// encoder setup bits and the quant scale new flag
	localparam int CFG_VIDEO    = 0;
	localparam int CFG_HSHAKE   = 1;
	localparam int CFG_RETRY    = 2;
	localparam int CFG_HOST_RDY = 3;
	localparam int CFG_SCALE_QT = 4;
	localparam int CFG_AUTO_QT  = 5;
	localparam int CFG_QT_LSB   = 6;
	localparam int QS_NEW       = 7;
	// pixel encodings
	localparam logic [7:0] FMT_YCC422 = 8'h00;
	localparam logic [7:0] FMT_YCC420 = 8'h01;
	localparam logic [7:0] FMT_MONO   = 8'h02;
	// output buffer and pixel clock half periods in link cycles
	localparam logic [10:0] FIFO_BYTES = 11'd1600;
	localparam logic [10:0] FIFO_ROOM  = 11'd1596;
	localparam logic [10:0] FIFO_START = 11'd800;
	localparam logic [1:0]  FAST_HALF  = 2'h1;
	localparam logic [1:0]  SLOW_HALF  = 2'h2;

	typedef enum logic [1:0] {
		RGB565  = 2'h0,
		RGB555  = 2'h1,
		RGB444X = 2'h2,
		RGBX444 = 2'h3
	} iof_rgb_t;

	typedef enum logic [3:0] {
		DRV_IDLE   = 4'b0001,
		DRV_ENCODE = 4'b0010,
		DRV_WAIT   = 4'b0100,
		DRV_STOP   = 4'b1000
	} iof_drv_t;

	typedef struct packed {
		logic       rgb_out;
		iof_rgb_t   rgb_mode;
		logic       swap_chroma;
		logic       swap_luma;
		logic       use_fifo;
		logic       decimated;
	} iof_fmt_cfg_t;

	// yuv pair or two rgb pixels, with line and frame end marks
	typedef struct packed {
		logic [7:0] y0;
		logic [7:0] cb;
		logic [7:0] y1;
		logic [7:0] cr;
		logic [7:0] r0;
		logic [7:0] g0;
		logic [7:0] b0;
		logic [7:0] r1;
		logic [7:0] g1;
		logic [7:0] b1;
		logic       eol;
		logic       eof;
	} iof_pix_t;

	// four output bytes, first byte in the top lane
	typedef struct packed {
		logic [31:0] bytes;
		logic        eol;
		logic        eof;
	} iof_grp_t;

	typedef struct packed {
		logic [7:0]  encoding;
		logic        video;
		logic        scaled_qt;
		logic        auto_qt;
		logic [1:0]  qt_id;
		logic [15:0] resync;
		logic [7:0]  qs1;
		logic [7:0]  qs2;
		logic [7:0]  qs3;
	} iof_enc_cfg_t;
endpackage
`default_nettype wire

// ---- logic/iof_formatter.sv ----
// image output formatter: encoder driver variables and handshake,
// byte ordering, and the pixel output stage on the link clock.
// assumes pixel groups arrive on clk; link_clk is a free-running clock.
`default_nettype none
module iof_formatter
	import iof_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         ce,
	input  wire logic         link_clk,
	input  wire logic         var_sel,
	input  wire logic         var_wr,
	input  wire logic [4:0]   var_addr,
	input  wire logic [7:0]   var_wdata,
	output logic [7:0]        var_rdata,
	input  wire logic [15:0]  mode_cols,
	input  wire logic [15:0]  mode_rows,
	input  wire logic         enc_go,
	input  wire logic         enc_done,
	input  wire logic         enc_fail,
	input  wire logic [23:0]  enc_len,
	input  wire logic         frame_tick,
	output iof_enc_cfg_t      enc_cfg,
	output logic              enc_run,
	output logic              enc_retry,
	input  wire iof_fmt_cfg_t fmt_cfg,
	input  wire logic         px_valid,
	input  wire iof_pix_t     px,
	output logic              px_ready,
	output logic              pixel_out_clock,
	output logic              frame_valid,
	output logic              line_valid,
	output logic [7:0]        dout
);

	function automatic logic [31:0] order_ycc(input iof_pix_t p,
		input logic sc, input logic sl);
		logic [7:0] c0;
		logic [7:0] c1;
		c0 = sc ? p.cr : p.cb;
		c1 = sc ? p.cb : p.cr;
		return sl ? {p.y0, c0, p.y1, c1} : {c0, p.y0, c1, p.y1};
	endfunction

	// odd byte, sent first, in the top half
	function automatic logic [15:0] pack_rgb(input iof_rgb_t m,
		input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
		logic [15:0] w;
		w = 16'h0000;
		case (m)
			RGB565:  w = {r[7:3], g[7:5], g[4:2], b[7:3]};
			RGB555:  w = {1'b0, r[7:3], g[7:6], g[4:2], b[7:3]};
			RGB444X: w = {r[7:4], g[7:4], b[7:4], 4'h0};
			default: w = {4'h0, r[7:4], g[7:4], b[7:4]};
		endcase
		return w;
	endfunction

	function automatic logic [15:0] rgb_px(input iof_fmt_cfg_t c,
		input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
		logic [15:0] w;
		w = c.swap_chroma ? pack_rgb(c.rgb_mode, b, g, r)
			: pack_rgb(c.rgb_mode, r, g, b);
		return c.swap_luma ? {w[7:0], w[15:8]} : w;
	endfunction

	function automatic logic [10:0] idx_add(input logic [10:0] i,
		input logic [2:0] k);
		logic [11:0] s;
		s = {1'b0, i} + {9'h000, k};
		return (s >= {1'b0, FIFO_BYTES}) ? 11'(s - {1'b0, FIFO_BYTES})
			: s[10:0];
	endfunction

	function automatic logic [7:0] phase_code(input iof_drv_t s);
		logic [7:0] v;
		v = 8'h00;
		case (s)
			DRV_ENCODE: v = 8'h01;
			DRV_WAIT:   v = 8'h02;
			DRV_STOP:   v = 8'h03;
			default:    v = 8'h00;
		endcase
		return v;
	endfunction

	// ---------------- encoder driver variables (clk) ----------------
	logic [15:0] dispatch_r;
	logic [15:0] cols_r;
	logic [15:0] rows_r;
	logic [7:0]  encoding_r;
	logic [7:0]  setup_r;
	logic [15:0] resync_r;
	logic [7:0]  qs1_r;
	logic [7:0]  qs2_r;
	logic [7:0]  qs3_r;
	logic [7:0]  wait_lim_r;
	logic [23:0] len_r;
	logic [7:0]  wait_cnt_r;
	logic [7:0]  var_rdata_r;
	logic        enc_run_r;
	logic        enc_retry_r;
	iof_drv_t    drv_r;
	iof_drv_t    drv_nxt;
	logic        wr;
	logic        host_rdy_clr;
	logic        qs_consume;
	logic        fail_resume;

	assign wr = ce && var_sel && var_wr;

	// read-only size mirrors
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cols_r <= RST_COLS;
			rows_r <= RST_ROWS;
		end else if (ce) begin
			cols_r <= mode_cols;
			rows_r <= mode_rows;
		end
	end

	// writable variables
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dispatch_r <= RST_DISPATCH;
			encoding_r <= RST_ENCODING;
			resync_r   <= RST_RESYNC;
			wait_lim_r <= RST_WAIT_LIM;
		end else if (wr) begin
			if (var_addr == OFS_DISPATCH)
				dispatch_r[15:8] <= var_wdata;
			else if (var_addr == OFS_DISPATCH + 5'h01)
				dispatch_r[7:0] <= var_wdata;
			else if (var_addr == OFS_ENCODING)
				encoding_r <= var_wdata;
			else if (var_addr == OFS_RESYNC)
				resync_r[15:8] <= var_wdata;
			else if (var_addr == OFS_RESYNC + 5'h01)
				resync_r[7:0] <= var_wdata;
			else if (var_addr == OFS_WAIT_LIM)
				wait_lim_r <= var_wdata;
		end
	end

	// setup variable; a host write wins over the hardware clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			setup_r <= RST_SETUP;
		end else if (ce) begin
			if (wr && var_addr == OFS_SETUP)
				setup_r <= var_wdata;
			else if (host_rdy_clr)
				setup_r[CFG_HOST_RDY] <= 1'b0;
		end
	end

	// quant scales; new flag drops once a frame picks it up
	always_ff @(posedge clk) begin
		if (!rstn) begin
			qs1_r <= RST_QS1;
			qs2_r <= RST_QS2;
			qs3_r <= RST_QS3;
		end else if (ce) begin
			if (wr && var_addr == OFS_QS1)
				qs1_r <= var_wdata;
			else if (qs_consume)
				qs1_r[QS_NEW] <= 1'b0;
			if (wr && var_addr == OFS_QS2)
				qs2_r <= var_wdata;
			else if (qs_consume)
				qs2_r[QS_NEW] <= 1'b0;
			if (wr && var_addr == OFS_QS3)
				qs3_r <= var_wdata;
			else if (qs_consume)
				qs3_r[QS_NEW] <= 1'b0;
		end
	end

	// read port, one cycle after the access
	always_ff @(posedge clk) begin
		if (!rstn) begin
			var_rdata_r <= 8'h00;
		end else if (ce && var_sel && !var_wr) begin
			if (var_addr == OFS_DISPATCH)
				var_rdata_r <= dispatch_r[15:8];
			else if (var_addr == OFS_DISPATCH + 5'h01)
				var_rdata_r <= dispatch_r[7:0];
			else if (var_addr == OFS_COLS)
				var_rdata_r <= cols_r[15:8];
			else if (var_addr == OFS_COLS + 5'h01)
				var_rdata_r <= cols_r[7:0];
			else if (var_addr == OFS_ROWS)
				var_rdata_r <= rows_r[15:8];
			else if (var_addr == OFS_ROWS + 5'h01)
				var_rdata_r <= rows_r[7:0];
			else if (var_addr == OFS_ENCODING)
				var_rdata_r <= encoding_r;
			else if (var_addr == OFS_SETUP)
				var_rdata_r <= setup_r;
			else if (var_addr == OFS_RESYNC)
				var_rdata_r <= resync_r[15:8];
			else if (var_addr == OFS_RESYNC + 5'h01)
				var_rdata_r <= resync_r[7:0];
			else if (var_addr == OFS_QS1)
				var_rdata_r <= qs1_r;
			else if (var_addr == OFS_QS2)
				var_rdata_r <= qs2_r;
			else if (var_addr == OFS_QS3)
				var_rdata_r <= qs3_r;
			else if (var_addr == OFS_WAIT_LIM)
				var_rdata_r <= wait_lim_r;
			else if (var_addr == OFS_PHASE)
				var_rdata_r <= phase_code(drv_r);
			else if (var_addr == OFS_LEN_UP)
				var_rdata_r <= len_r[23:16];
			else if (var_addr == OFS_LEN_LO)
				var_rdata_r <= len_r[15:8];
			else if (var_addr == OFS_LEN_LO + 5'h01)
				var_rdata_r <= len_r[7:0];
			else
				var_rdata_r <= 8'h00;
		end
	end

	// driver sequence
	always_comb begin
		drv_nxt = drv_r;
		host_rdy_clr = 1'b0;
		fail_resume = 1'b0;
		case (drv_r)
			DRV_IDLE, DRV_STOP: begin
				if (enc_go)
					drv_nxt = DRV_ENCODE;
			end
			DRV_ENCODE: begin
				if (enc_fail && setup_r[CFG_HSHAKE])
					drv_nxt = DRV_WAIT;
				else if (enc_fail && setup_r[CFG_RETRY])
					fail_resume = 1'b1;
				else if ((enc_done || enc_fail) && !setup_r[CFG_VIDEO])
					drv_nxt = DRV_STOP;
			end
			DRV_WAIT: begin
				if (setup_r[CFG_HOST_RDY]) begin
					host_rdy_clr = 1'b1;
					fail_resume = setup_r[CFG_RETRY];
					drv_nxt = DRV_ENCODE;
				end else if (wait_cnt_r >= wait_lim_r) begin
					fail_resume = setup_r[CFG_RETRY];
					drv_nxt = DRV_ENCODE;
				end
			end
			default: drv_nxt = DRV_IDLE;
		endcase
	end

	assign qs_consume = (drv_r == DRV_ENCODE) && frame_tick;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			drv_r       <= DRV_IDLE;
			enc_run_r   <= 1'b0;
			enc_retry_r <= 1'b0;
			wait_cnt_r  <= 8'h00;
		end else if (ce) begin
			drv_r       <= drv_nxt;
			enc_run_r   <= (drv_nxt == DRV_ENCODE);
			enc_retry_r <= fail_resume;
			if (drv_r != DRV_WAIT)
				wait_cnt_r <= 8'h00;
			else if (frame_tick)
				wait_cnt_r <= wait_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			len_r <= 24'h000000;
		else if (ce && drv_r == DRV_ENCODE && (enc_done || enc_fail))
			len_r <= enc_len;
	end

	assign enc_cfg = '{encoding: encoding_r, video: setup_r[CFG_VIDEO],
		scaled_qt: setup_r[CFG_SCALE_QT], auto_qt: setup_r[CFG_AUTO_QT],
		qt_id: setup_r[CFG_QT_LSB+1:CFG_QT_LSB], resync: resync_r,
		qs1: qs1_r, qs2: qs2_r, qs3: qs3_r};
	assign var_rdata = var_rdata_r;
	assign enc_run   = enc_run_r;
	assign enc_retry = enc_retry_r;

	// ---------------- byte ordering and hand-over (clk) ---------------
	iof_grp_t hs_word_r;
	logic     hs_req_r;
	logic     px_ready_r;
	logic     ack_s1_r;
	logic     ack_s2_r;
	logic     ack_r;

	always_ff @(posedge clk) begin
		ack_s1_r <= ack_r;
		ack_s2_r <= ack_s1_r;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			hs_req_r   <= 1'b0;
			px_ready_r <= 1'b1;
			hs_word_r  <= '0;
		end else if (ce) begin
			if (px_valid && px_ready_r) begin
				hs_word_r.bytes <= fmt_cfg.rgb_out
					? {rgb_px(fmt_cfg, px.r0, px.g0, px.b0),
					   rgb_px(fmt_cfg, px.r1, px.g1, px.b1)}
					: order_ycc(px, fmt_cfg.swap_chroma,
						fmt_cfg.swap_luma);
				hs_word_r.eol <= px.eol;
				hs_word_r.eof <= px.eof;
				hs_req_r      <= ~hs_req_r;
				px_ready_r    <= 1'b0;
			end else if (!px_ready_r && ack_s2_r == hs_req_r) begin
				px_ready_r <= 1'b1;
			end
		end
	end
	assign px_ready = px_ready_r;

	// ---------------- output stage (link_clk) ----------------
	logic        lrst_s1_r;
	logic        lrst_s2_r;
	logic        lce_s1_r;
	logic        lce_s2_r;
	logic        req_s1_r;
	logic        req_s2_r;
	logic        req_seen_r;
	logic        fifo_s1_r;
	logic        fifo_s2_r;
	logic        dec_s1_r;
	logic        dec_s2_r;
	logic [9:0]  mem_r [FIFO_BYTES];
	logic [10:0] wr_idx_r;
	logic [10:0] rd_idx_r;
	logic [10:0] cnt_r;
	logic [10:0] lines_r;
	logic [1:0]  ph_r;
	logic        pclk_r;
	logic        slow_r;
	logic        fv_r;
	logic        lv_r;
	logic [7:0]  dout_r;
	logic        in_line_r;
	logic        gap_r;
	logic        end_r;
	logic        lce;
	logic        accept;
	logic        fall;
	logic        may_send;
	logic        pop;
	logic [9:0]  head;

	always_ff @(posedge link_clk) begin
		lrst_s1_r <= rstn;
		lrst_s2_r <= lrst_s1_r;
		lce_s1_r  <= ce;
		lce_s2_r  <= lce_s1_r;
		req_s1_r  <= hs_req_r;
		req_s2_r  <= req_s1_r;
		fifo_s1_r <= fmt_cfg.use_fifo;
		fifo_s2_r <= fifo_s1_r;
		dec_s1_r  <= fmt_cfg.decimated;
		dec_s2_r  <= dec_s1_r;
	end

	assign lce  = lce_s2_r;
	assign head = mem_r[rd_idx_r];
	// direct path holds one group only; buffered path fills the store
	assign accept = lce && (req_s2_r != req_seen_r) && (fifo_s2_r
		? (cnt_r <= FIFO_ROOM) : (cnt_r == 11'd0));
	assign fall = lce && pclk_r
		&& (ph_r + 2'h1 >= (slow_r ? SLOW_HALF : FAST_HALF));
	// buffered lines start only once a line or half the store is held
	assign may_send = fifo_s2_r ? (in_line_r || lines_r != 11'd0
		|| cnt_r >= FIFO_START) : 1'b1;
	assign pop = fall && !gap_r && !end_r && cnt_r != 11'd0 && may_send;

	// byte store and hand-over acknowledge
	always_ff @(posedge link_clk) begin
		if (!lrst_s2_r) begin
			wr_idx_r   <= 11'd0;
			rd_idx_r   <= 11'd0;
			cnt_r      <= 11'd0;
			lines_r    <= 11'd0;
			req_seen_r <= 1'b0;
			ack_r      <= 1'b0;
		end else begin
			if (accept) begin
				for (int k = 0; k < 4; k++)
					mem_r[idx_add(wr_idx_r, 3'(k))] <= {
						(k == 3) && hs_word_r.eol, (k == 3) && hs_word_r.eof,
						hs_word_r.bytes[31 - 8*k -: 8]};
				wr_idx_r   <= idx_add(wr_idx_r, 3'h4);
				req_seen_r <= req_s2_r;
				ack_r      <= req_s2_r;
			end
			if (pop)
				rd_idx_r <= idx_add(rd_idx_r, 3'h1);
			cnt_r <= cnt_r + (accept ? 11'd4 : 11'd0)
				- (pop ? 11'd1 : 11'd0);
			lines_r <= lines_r + ((accept && hs_word_r.eol) ? 11'd1 : 11'd0)
				- ((pop && head[9]) ? 11'd1 : 11'd0);
		end
	end

	// pixel clock divider; rate changes only outside line valid
	always_ff @(posedge link_clk) begin
		if (!lrst_s2_r) begin
			ph_r   <= 2'h0;
			pclk_r <= 1'b0;
			slow_r <= 1'b0;
		end else if (lce) begin
			if (ph_r + 2'h1 >= (slow_r ? SLOW_HALF : FAST_HALF)) begin
				ph_r   <= 2'h0;
				pclk_r <= ~pclk_r;
			end else begin
				ph_r <= ph_r + 2'h1;
			end
			if (!lv_r && !pclk_r)
				slow_r <= fifo_s2_r && dec_s2_r;
		end
	end

	// frame, line and data; all change on the falling pixel clock
	always_ff @(posedge link_clk) begin
		if (!lrst_s2_r) begin
			fv_r      <= 1'b0;
			lv_r      <= 1'b0;
			dout_r    <= 8'h00;
			in_line_r <= 1'b0;
			gap_r     <= 1'b0;
			end_r     <= 1'b0;
		end else if (fall) begin
			if (pop) begin
				dout_r    <= head[7:0];
				lv_r      <= 1'b1;
				fv_r      <= 1'b1;
				in_line_r <= !head[9] && !head[8];
				gap_r     <= head[9];
				end_r     <= head[8];
			end else begin
				lv_r  <= 1'b0;
				gap_r <= 1'b0;
				if (end_r) begin
					fv_r  <= 1'b0;
					end_r <= 1'b0;
				end
			end
		end
	end

	assign pixel_out_clock = pclk_r;
	assign frame_valid     = fv_r;
	assign line_valid      = lv_r;
	assign dout            = dout_r;

endmodule
`default_nettype wire

// ---- verification/iof_props.sv ----
// checker for the image output formatter, bound to its ports.
// assumes the link side leaves reset a few link edges after rstn.
`default_nettype none
module iof_props
	import iof_pkg::*;
(
	input wire logic         clk,
	input wire logic         rstn,
	input wire logic         ce,
	input wire logic         link_clk,
	input wire logic         var_sel,
	input wire logic         var_wr,
	input wire logic [4:0]   var_addr,
	input wire logic [7:0]   var_wdata,
	input wire logic [7:0]   var_rdata,
	input wire logic         enc_done,
	input wire iof_enc_cfg_t enc_cfg,
	input wire logic         enc_run,
	input wire logic         enc_retry,
	input wire iof_fmt_cfg_t fmt_cfg,
	input wire logic         px_valid,
	input wire logic         px_ready,
	input wire logic         pixel_out_clock,
	input wire logic         frame_valid,
	input wire logic         line_valid,
	input wire logic [7:0]   dout
);
	timeunit 1ns;
	timeprecision 1ns;
	sequence s_take;
		ce && px_valid && px_ready;
	endsequence
	sequence s_slow_high;
		pixel_out_clock ##1 !pixel_out_clock;
	endsequence
	a_cfg_encoding: assert property (
		@(posedge clk) disable iff (!rstn)
		ce && var_sel && var_wr && var_addr == OFS_ENCODING
		|=> enc_cfg.encoding == $past(var_wdata))
		else $error("encoding not written");
	a_rdata_cause: assert property (
		@(posedge clk) disable iff (!rstn)
		$changed(var_rdata) |-> $past(ce && var_sel && !var_wr))
		else $error("read data moved without a read");
	a_ready_drop: assert property (
		@(posedge clk) disable iff (!rstn)
		s_take |=> !px_ready)
		else $error("ready held after a take");
	a_still_stop: assert property (
		@(posedge clk) disable iff (!rstn)
		enc_run && ce && enc_done && !enc_cfg.video |=> !enc_run)
		else $error("snapshot kept encoding");
	a_retry_pulse: assert property (
		@(posedge clk) disable iff (!rstn)
		enc_retry |=> !enc_retry)
		else $error("retry longer than a cycle");
	a_lv_in_fv: assert property (
		@(posedge link_clk) disable iff (!rstn)
		line_valid |-> frame_valid)
		else $error("line valid outside frame");
	a_out_edges: assert property (
		@(posedge link_clk) disable iff (!rstn)
		$changed({frame_valid, line_valid, dout})
		|-> $fell(pixel_out_clock))
		else $error("output moved off a clock fall");
	a_fast_pclk: assert property (
		@(posedge link_clk) disable iff (!rstn)
		line_valid && $past(line_valid)
		&& !(fmt_cfg.use_fifo && fmt_cfg.decimated)
		|-> pixel_out_clock != $past(pixel_out_clock))
		else $error("fast pixel clock irregular");
	a_slow_pclk: assert property (
		@(posedge link_clk) disable iff (!rstn)
		$rose(pixel_out_clock) && line_valid
		&& fmt_cfg.use_fifo && fmt_cfg.decimated |=> s_slow_high)
		else $error("buffered pixel clock not slow");
endmodule
bind iof_formatter iof_props u_props (
	.clk, .rstn, .ce, .link_clk, .var_sel, .var_wr, .var_addr,
	.var_wdata, .var_rdata, .enc_done, .enc_cfg, .enc_run, .enc_retry,
	.fmt_cfg, .px_valid, .px_ready, .pixel_out_clock, .frame_valid,
	.line_valid, .dout
);
`default_nettype wire

// ---- verification/iof_pix_rx.sv ----
// pixel port receiver: takes bytes on the rising pixel clock.
// assumes data and line valid move on the falling edge.
`default_nettype none
module iof_pix_rx (
	input wire logic       pclk,
	input wire logic       fv,
	input wire logic       lv,
	input wire logic [7:0] d
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$];
	int         lines = 0;
	always @(posedge pclk)
		if (lv && fv)
			got.push_back(d);
	always @(negedge lv)
		lines++;
endmodule
`default_nettype wire

// ---- verification/iof_formatter_bench.sv ----
// bench for the image output formatter: variables, driver, pixel port.
// assumes the receiver model and the bound checker are compiled first.
`default_nettype none
module iof_formatter_bench
	import iof_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [119:0] RST_TAB =
		120'he453_0640_04b0_0034_0000_0609_0c0a_00;
	localparam logic [127:0] YCC_TAB =
		128'h20104030_10203040_40102030_10403020;
	logic         clk, rstn, ce, link_clk, var_sel, var_wr;
	logic         enc_go, enc_done, enc_fail, frame_tick, px_valid;
	logic [4:0]   var_addr;
	logic [7:0]   var_wdata, var_rdata, dout;
	logic [15:0]  mode_cols, mode_rows;
	logic [23:0]  enc_len;
	iof_enc_cfg_t enc_cfg;
	iof_fmt_cfg_t fmt_cfg;
	iof_pix_t     px;
	logic         enc_run, enc_retry, px_ready, pixel_out_clock;
	logic         frame_valid, line_valid;
	int           error_cnt, total_checks;
	int           retry_n = 0;

	iof_formatter dut (
		.clk, .rstn, .ce, .link_clk, .var_sel, .var_wr, .var_addr,
		.var_wdata, .var_rdata, .mode_cols, .mode_rows, .enc_go,
		.enc_done, .enc_fail, .enc_len, .frame_tick, .enc_cfg, .enc_run,
		.enc_retry, .fmt_cfg, .px_valid, .px, .px_ready,
		.pixel_out_clock, .frame_valid, .line_valid, .dout
	);
	iof_pix_rx rx (
		.pclk(pixel_out_clock),
		.fv(frame_valid),
		.lv(line_valid),
		.d(dout)
	);

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	initial begin
		link_clk = 0;
		#7;
		forever #32 link_clk = ~link_clk;
	end
	// counts retry pulses; scenarios compare before and after
	always @(posedge clk)
		if (enc_retry === 1'b1)
			retry_n++;

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic fail_out;
		error_cnt++;
		$display("MISMATCH t=%0t wait ran out", $time);
		wrap_up();
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] e);
		total_checks++;
		if (got !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, e);
		end
	endtask
	task automatic chk(input logic ok);
		total_checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("MISMATCH t=%0t flag wrong", $time);
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(negedge clk);
		{var_sel, var_wr, var_addr} = {2'b10, a};
		@(negedge clk);
		var_sel = 0;
		cmp8(var_rdata, e);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk);
		{var_sel, var_wr, var_addr, var_wdata} = {2'b11, a, d};
		@(negedge clk);
		var_sel = 0;
		@(negedge clk);
	endtask
	// go, done, fail, tick from the top bit down
	task automatic pulse(input logic [3:0] m);
		@(negedge clk);
		{enc_go, enc_done, enc_fail, frame_tick} = m;
		@(negedge clk);
		{enc_go, enc_done, enc_fail, frame_tick} = 4'h0;
	endtask
	task automatic send(input iof_pix_t g);
		int i;
		@(negedge clk);
		px = g;
		px_valid = 1;
		for (i = 0; i < 300 && px_ready !== 1'b1; i++)
			@(negedge clk);
		@(negedge clk);
		px_valid = 0;
		if (i == 300)
			fail_out();
	endtask
	task automatic drain(input int n);
		int i;
		for (i = 0; i < 600 && rx.got.size() < n; i++)
			@(negedge clk);
		repeat (8) @(negedge clk);
		if (i == 600)
			fail_out();
	endtask
	task automatic chk_grp(input logic [31:0] e);
		int i;
		for (i = 0; i < 4; i++)
			cmp8(rx.got.pop_front(), e[31 - 8 * i -: 8]);
	endtask
	// odd byte first, swaps applied as the pixel port expects
	function automatic logic [15:0] pk(input iof_fmt_cfg_t c,
		input logic [7:0] r0, input logic [7:0] g, input logic [7:0] b0);
		logic [7:0]  r, b;
		logic [15:0] w;
		r = c.swap_chroma ? b0 : r0;
		b = c.swap_chroma ? r0 : b0;
		case (c.rgb_mode)
			RGB565:  w = {r[7:3], g[7:2], b[7:3]};
			RGB555:  w = {1'b0, r[7:3], g[7:6], g[4:2], b[7:3]};
			RGB444X: w = {r[7:4], g[7:4], b[7:4], 4'h0};
			default: w = {4'h0, r[7:4], g[7:4], b[7:4]};
		endcase
		return c.swap_luma ? {w[7:0], w[15:8]} : w;
	endfunction

	initial begin
		int          k, n;
		iof_pix_t    p;
		logic [31:0] e;
		error_cnt = 0;
		total_checks = 0;
		rstn = 0;
		ce = 1;
		{var_sel, var_wr, enc_go, enc_done, enc_fail, frame_tick} = '0;
		{var_addr, var_wdata, enc_len, px_valid, px} = '0;
		mode_cols = RST_COLS;
		mode_rows = RST_ROWS;
		fmt_cfg = '0;
		repeat (10) @(negedge clk);
		rstn = 1;
		for (k = 0; k < 15; k++)
			rd(k[4:0], RST_TAB[119 - 8 * k -: 8]);
		rd(5'h12, 8'h00);
		wr(OFS_COLS, 8'hff);
		rd(OFS_COLS, 8'h06);
		mode_rows = 16'h0258;
		rd(OFS_ROWS + 5'h01, 8'h58);
		for (k = 0; k < 3; k++) begin
			wr(OFS_ENCODING, k[7:0]);
			rd(OFS_ENCODING, k[7:0]);
		end
		wr(OFS_RESYNC + 5'h01, 8'h08);
		chk(enc_cfg.resync === 16'h0008);
		wr(OFS_QS1, 8'h85);
		cmp8(enc_cfg.qs1, 8'h85);
		wr(OFS_SETUP, 8'hb6);
		e = {28'h0, enc_cfg.qt_id, enc_cfg.scaled_qt, enc_cfg.auto_qt};
		cmp8(e[7:0], 8'h0b);
		enc_len = 24'h123456;
		pulse(4'h8);
		chk(enc_run === 1'b1);
		pulse(4'h1);
		cmp8(enc_cfg.qs1, 8'h05);
		pulse(4'h2);
		chk(enc_run === 1'b0);
		rd(OFS_PHASE, 8'h02);
		rd(OFS_LEN_UP, 8'h12);
		rd(OFS_LEN_LO, 8'h34);
		rd(OFS_LEN_LO + 5'h01, 8'h56);
		// retry pulse stands in the same cycle as the resumed run
		wr(OFS_SETUP, 8'hbe);
		chk(enc_run === 1'b1 && enc_retry === 1'b1);
		rd(OFS_SETUP, 8'hb6);
		wr(OFS_WAIT_LIM, 8'h02);
		pulse(4'h2);
		pulse(4'h1);
		rd(OFS_PHASE, 8'h02);
		pulse(4'h1);
		pulse(4'h0);
		chk(enc_run === 1'b1);
		wr(OFS_SETUP, 8'h34);
		n = retry_n;
		pulse(4'h2);
		pulse(4'h0);
		chk(retry_n != n);
		wr(OFS_SETUP, 8'h30);
		pulse(4'h8);
		n = retry_n;
		pulse(4'h2);
		pulse(4'h0);
		chk(retry_n == n);
		rd(OFS_PHASE, 8'h03);
		wr(OFS_SETUP, 8'h31);
		pulse(4'h8);
		pulse(4'h4);
		pulse(4'h0);
		chk(enc_run === 1'b1);
		wr(OFS_SETUP, 8'h30);
		pulse(4'h4);
		chk(enc_run === 1'b0);
		p = '0;
		{p.y0, p.cb, p.y1, p.cr} = 32'h10203040;
		{p.r0, p.g0, p.b0, p.r1, p.g1, p.b1} = 48'hf15a3c_0ea7c3;
		p.eol = 1;
		p.eof = 1;
		for (k = 0; k < 10; k++) begin
			fmt_cfg = '0;
			fmt_cfg.rgb_out = k > 3;
			fmt_cfg.rgb_mode = iof_rgb_t'(k[1:0]);
			fmt_cfg.swap_chroma = k inside {2, 3, 8};
			fmt_cfg.swap_luma = k inside {1, 3, 9};
			e = {pk(fmt_cfg, p.r0, p.g0, p.b0), pk(fmt_cfg, p.r1, p.g1, p.b1)};
			if (k < 4)
				e = YCC_TAB[127 - 32 * k -: 32];
			send(p);
			drain(4);
			chk_grp(e);
		end
		for (k = 0; k < 2; k++) begin
			fmt_cfg = '0;
			fmt_cfg.decimated = 1;
			fmt_cfg.use_fifo = k[0];
			n = rx.lines;
			{p.eol, p.eof} = 2'b00;
			send(p);
			// decimated source: idle spell between the two groups
			repeat (40) @(negedge clk);
			{p.eol, p.eof} = 2'b11;
			send(p);
			drain(8);
			chk_grp(YCC_TAB[127 -: 32]);
			chk_grp(YCC_TAB[127 -: 32]);
			chk(rx.lines - n === 2 - k);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
